/* sps_pkg.sv */
// Purpose: Shared constants for the supply program sequencer.
// Assumes: Avalon-MM slave, 32-bit data, word addressed by byte offset.
// Notes:   Levels are raw fixed-point codes; scaling is done by software.
package sps_pkg;
    // Register byte offsets
    localparam logic [7:0] SPS_REG_CMD        = 8'h00;
    localparam logic [7:0] SPS_REG_ARG        = 8'h04;
    localparam logic [7:0] SPS_REG_RESULT     = 8'h08;
    localparam logic [7:0] SPS_REG_STATUS     = 8'h0C;
    localparam logic [7:0] SPS_REG_QUEST      = 8'h10;
    localparam logic [7:0] SPS_REG_ERROR      = 8'h14;
    localparam logic [7:0] SPS_REG_MEAS_AMPS  = 8'h18;
    localparam logic [7:0] SPS_REG_MEASURE_POTENTIAL_QUERY  = 8'h1C;
    localparam logic [7:0] SPS_REG_DRIVE_AMPS = 8'h20;
    localparam logic [7:0] SPS_REG_DRIVE_VOLT = 8'h24;

    // Command codes written to the command register
    localparam logic [7:0] SPS_CMD_SET_START    = 8'h01;
    localparam logic [7:0] SPS_CMD_GET_START    = 8'h02;
    localparam logic [7:0] SPS_CMD_SET_INDEX    = 8'h03;
    localparam logic [7:0] SPS_CMD_GET_INDEX    = 8'h04;
    localparam logic [7:0] SPS_CMD_SET_STEP_V   = 8'h05;
    localparam logic [7:0] SPS_CMD_GET_STEP_V   = 8'h06;
    localparam logic [7:0] SPS_CMD_SET_STEP_OV  = 8'h07;
    localparam logic [7:0] SPS_CMD_GET_STEP_OV  = 8'h08;
    localparam logic [7:0] SPS_CMD_SET_DWELL    = 8'h09;
    localparam logic [7:0] SPS_CMD_GET_DWELL    = 8'h0A;
    localparam logic [7:0] SPS_CMD_SET_NEXT     = 8'h0B;
    localparam logic [7:0] SPS_CMD_GET_NEXT     = 8'h0C;
    localparam logic [7:0] SPS_CMD_MEAS_AMPS    = 8'h0D;
    localparam logic [7:0] SPS_CMD_MEASURE_POTENTIAL_QUERY    = 8'h0E;
    localparam logic [7:0] SPS_CMD_READ_AMPS    = 8'h0F;
    localparam logic [7:0] SPS_CMD_READ_VOLT    = 8'h10;
    localparam logic [7:0] SPS_CMD_SET_OUTPUT   = 8'h11;
    localparam logic [7:0] SPS_CMD_GET_OUTPUT   = 8'h12;
    localparam logic [7:0] SPS_CMD_SET_DELAY    = 8'h13;
    localparam logic [7:0] SPS_CMD_GET_DELAY    = 8'h14;
    localparam logic [7:0] SPS_CMD_PROG_RUN     = 8'h15;
    localparam logic [7:0] SPS_CMD_PROG_STOP    = 8'h16;
    localparam logic [7:0] SPS_CMD_GET_PROG     = 8'h17;
    localparam logic [7:0] SPS_CMD_SET_AMPS     = 8'h18;
    localparam logic [7:0] SPS_CMD_GET_AMPS     = 8'h19;
    localparam logic [7:0] SPS_CMD_GET_AMPS_MAX = 8'h1A;
    localparam logic [7:0] SPS_CMD_GET_AMPS_MIN = 8'h1B;
    localparam logic [7:0] SPS_CMD_SET_HILIM    = 8'h1C;
    localparam logic [7:0] SPS_CMD_SET_TRIG_A   = 8'h1D;
    localparam logic [7:0] SPS_CMD_GET_TRIG_A   = 8'h1E;
    localparam logic [7:0] SPS_CMD_TRIGGER      = 8'h1F;
    localparam logic [7:0] SPS_CMD_RESET        = 8'h20;
    localparam logic [7:0] SPS_CMD_SET_VOLT     = 8'h21;

    // Command argument field: bit 16 flags trailing range characters
    localparam int SPS_ARG_EXTRA_BIT = 16;

    localparam logic [15:0] SPS_ERR_RANGE = 16'hFF22; // -222
    localparam int          SPS_QUEST_WARN_BIT = 13;

    // Location numbering
    localparam logic [5:0] SPS_LOC_MIN = 6'h01;
    localparam logic [5:0] SPS_LOC_MAX = 6'h28;

    // Reset values of the working registers
    localparam logic [5:0]  SPS_RST_START = 6'h01;
    localparam logic [5:0]  SPS_RST_INDEX = 6'h01;
    localparam logic [15:0] SPS_RST_HILIM = 16'hFFFF;

    // Timing: dwell unit 0.01 s, trip-delay unit 0.033 ms
    localparam int CLK_HZ           = 50_000_000;
    localparam int DWELL_UNIT_US    = 10_000;
    localparam int DWELL_UNIT_CYC   = DWELL_UNIT_US * (CLK_HZ / 1_000_000);
    localparam int TRIP_UNIT_NS     = 33_000;
    localparam int TRIP_UNIT_CYC    = TRIP_UNIT_NS / (1_000_000_000 / CLK_HZ);
    localparam logic [14:0] SPS_DWELL_MAX = 15'h7530; // 300 s
    localparam logic [17:0] SPS_DELAY_MAX = 18'h3E5D5; // ~8.43 s
endpackage

/* sps_core.sv */
// Purpose: Command core of a programmable DC source with stored program.
// Assumes: Commands arrive as code plus argument over Avalon-MM.
// Notes:   Program memory is held in flops; retention is the host's concern.
// Behaviour
// [RULE1] Start location 1..40 begins run
// [RULE2] Start location kept in retained storage; here rst_in reloads it to SPS_RST_START
// [RULE3] Start query returns last written value
// [RULE4] Step voltage stored; out of range posts -222
// [RULE5] Step protection stored; out of range posts -222
// [RULE6] Step voltage query reads indexed location
// [RULE7] Step protection query reads indexed location
// [RULE8] Measurement queries return sensed terminal values
// [RULE9] Extra query characters set questionable bit 13
// [RULE10] Read queries equal measurement queries
// [RULE11] Output enabled after power-up
// [RULE12] Off saves levels, drives zero; on restores
// [RULE13] Output query answers 0 off, 1 on
// [RULE14] Trip delay counted in 0.033 ms steps
// [RULE15] Delayed trip only if fault persists
// [RULE16] Run starts at start location; stop halts
// [RULE17] Keyboard locked while program runs
// [RULE18] Reset command aborts running program
// [RULE19] Program query answers 1 running, 0 stopped
// [RULE20] Level over maximum errors; over limit clamps
// [RULE21] Level query: programmed, maximum, or zero
// [RULE22] Triggered level applied on trigger command
// [RULE23] Dwell 0.01..300 s; zero skips location
// [RULE24] Next location zero ends program
// [RULE25] Index selects one of 40 locations
// [RULE26] Chain end clears run and lock together
`timescale 1ns/100ps
`default_nettype none
module sps_core
    import sps_pkg::*;
#(
    parameter int        LEVEL_W    = 16,
    parameter logic [15:0] AMPS_MAX = 16'hC350,
    parameter logic [15:0] VOLT_MAX = 16'hC350,
    parameter int        DWELL_CYC  = DWELL_UNIT_CYC,
    parameter int        TRIP_CYC   = TRIP_UNIT_CYC
) (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic [7:0]         avs_address_in,
    input  wire logic               avs_read_in,
    input  wire logic               avs_write_in,
    input  wire logic [31:0]        avs_writedata_in,
    input  wire logic [3:0]         avs_byteenable_in,
    output logic [31:0]             avs_readdata_out,
    output logic                    avs_waitrequest_out,
    input  wire logic [15:0]        sense_amps_in,
    input  wire logic [15:0]        sense_volt_in,
    input  wire logic               fault_ov_in,
    input  wire logic               fault_oc_in,
    output logic [15:0]             drive_amps_out,
    output logic [15:0]             drive_volt_out,
    output logic [15:0]             drive_ovp_out,
    output logic                    keyboard_lock_out,
    output logic                    protection_tripped_out
);
    typedef enum logic [1:0] {
        SPS_IDLE  = 2'b00,
        SPS_LOAD  = 2'b01,
        SPS_DWELL = 2'b10
    } sps_seq_e;

    typedef struct packed {
        logic [31:0]  rdata;
        logic         ack;
        logic [31:0]  arg;
        logic [31:0]  result;
        logic [15:0]  err;
        logic [15:0]  quest;
        logic [5:0]   start;
        logic [5:0]   index;
        logic         out_en;
        logic [15:0]  amps;
        logic [15:0]  volt;
        logic [15:0]  hilim;
        logic [15:0]  trig_amps;
        logic [17:0]  delay;
        logic [17:0]  trip_cnt;
        logic [15:0]  trip_pre;
        logic         tripped;
        sps_seq_e     seq;
        logic         running;
        logic [5:0]   cur;
        logic [14:0]  dwell_left;
        logic [19:0]  dwell_pre;
        logic [15:0]  d_amps;
        logic [15:0]  d_volt;
        logic [15:0]  d_ovp;
    } sps_state_s;

    sps_state_s st;
    sps_state_s next_st;

    // Program memory, one entry per location, retained across host resets
    logic [15:0] mem_volt  [1:40];
    logic [15:0] mem_ovp   [1:40];
    logic [14:0] mem_dwell [1:40];
    logic [5:0]  mem_next  [1:40];

    logic        cmd_go;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_val;

    function automatic logic loc_ok(input logic [15:0] v);
        return (v >= 16'(SPS_LOC_MIN)) && (v <= 16'(SPS_LOC_MAX));
    endfunction

    function automatic logic [15:0] clamp_amps(input logic [15:0] v, input logic [15:0] lim);
        return (v > lim) ? lim : v;
    endfunction

    assign cmd_go   = avs_write_in && !st.ack && avs_address_in == SPS_REG_CMD;
    assign cmd_code = avs_writedata_in[7:0];
    assign cmd_val  = st.arg[15:0];

    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        if ((avs_read_in || avs_write_in) && !st.ack) begin
            next_st.ack = 1'b1;
        end
        if (avs_read_in && !st.ack) begin
            case (avs_address_in)
                SPS_REG_ARG:        next_st.rdata = st.arg;
                SPS_REG_RESULT:     next_st.rdata = st.result;
                SPS_REG_STATUS:     next_st.rdata = {26'h0, st.tripped, st.running, 3'h0, st.out_en};
                SPS_REG_QUEST:      next_st.rdata = {16'h0, st.quest};
                SPS_REG_ERROR:      next_st.rdata = {16'h0, st.err};
                SPS_REG_MEAS_AMPS:  next_st.rdata = {16'h0, sense_amps_in};
                SPS_REG_MEASURE_POTENTIAL_QUERY:  next_st.rdata = {16'h0, sense_volt_in};
                SPS_REG_DRIVE_AMPS: next_st.rdata = {16'h0, st.d_amps};
                SPS_REG_DRIVE_VOLT: next_st.rdata = {16'h0, st.d_volt};
                default:            next_st.rdata = 32'h0;
            endcase
        end
        if (avs_write_in && !st.ack && avs_address_in == SPS_REG_ARG) begin
            next_st.arg = avs_writedata_in;
        end
        if (avs_write_in && !st.ack && avs_address_in == SPS_REG_ERROR) begin
            next_st.err = 16'h0;
        end
        if (avs_write_in && !st.ack && avs_address_in == SPS_REG_QUEST) begin
            next_st.quest = 16'h0;
        end

        // Protection delay: prescaler then count of 0.033 ms steps
        if (fault_ov_in || fault_oc_in) begin
            if (st.delay == 18'h0) begin
                next_st.tripped = 1'b1; // [RULE14]
            end else if (st.trip_pre >= 16'(TRIP_CYC - 1)) begin
                next_st.trip_pre = 16'h0;
                next_st.trip_cnt = st.trip_cnt + 18'h1;
                if (st.trip_cnt + 18'h1 >= st.delay) begin
                    next_st.tripped = 1'b1; // [RULE15]
                end
            end else begin
                next_st.trip_pre = st.trip_pre + 16'h1;
            end
        end else begin
            next_st.trip_pre = 16'h0; // [RULE15]
            next_st.trip_cnt = 18'h0;
        end

        // Sequencer
        case (st.seq)
            SPS_IDLE: ;
            SPS_LOAD: begin
                if (st.cur == 6'h0 || st.cur > SPS_LOC_MAX) begin
                    next_st.seq = SPS_IDLE; // [RULE24]
                    next_st.running = 1'b0; // [RULE26]
                end else if (mem_dwell[st.cur] == 15'h0) begin
                    next_st.cur = mem_next[st.cur]; // [RULE23]
                end else begin
                    next_st.volt = mem_volt[st.cur];
                    next_st.d_ovp = mem_ovp[st.cur];
                    next_st.dwell_left = mem_dwell[st.cur];
                    next_st.dwell_pre = 20'h0;
                    next_st.seq = SPS_DWELL;
                end
            end
            SPS_DWELL: begin
                if (st.dwell_pre >= 20'(DWELL_CYC - 1)) begin
                    next_st.dwell_pre = 20'h0;
                    next_st.dwell_left = st.dwell_left - 15'h1;
                    if (st.dwell_left == 15'h1) begin
                        next_st.cur = mem_next[st.cur]; // [RULE24]
                        next_st.seq = SPS_LOAD;
                    end
                end else begin
                    next_st.dwell_pre = st.dwell_pre + 20'h1;
                end
            end
            default: next_st.seq = SPS_IDLE;
        endcase

        if (cmd_go) begin
            case (cmd_code)
                SPS_CMD_SET_START: begin
                    if (loc_ok(cmd_val)) next_st.start = cmd_val[5:0];  // [RULE1] [RULE2]
                    else next_st.err = SPS_ERR_RANGE;
                end
                SPS_CMD_GET_START: next_st.result = {26'h0, st.start};  // [RULE3]
                SPS_CMD_SET_INDEX: begin
                    if (loc_ok(cmd_val)) next_st.index = cmd_val[5:0];  // [RULE25]
                    else next_st.err = SPS_ERR_RANGE;
                end
                SPS_CMD_GET_INDEX:   next_st.result = {26'h0, st.index};
                SPS_CMD_SET_STEP_V:  if (cmd_val > VOLT_MAX) next_st.err = SPS_ERR_RANGE;   // [RULE4]
                SPS_CMD_GET_STEP_V:  next_st.result = {16'h0, mem_volt[st.index]}; // [RULE6]
                SPS_CMD_SET_STEP_OV: if (cmd_val > VOLT_MAX) next_st.err = SPS_ERR_RANGE;   // [RULE5]
                SPS_CMD_GET_STEP_OV: next_st.result = {16'h0, mem_ovp[st.index]}; // [RULE7]
                SPS_CMD_SET_DWELL:   if (cmd_val > 16'(SPS_DWELL_MAX)) next_st.err = SPS_ERR_RANGE;
                SPS_CMD_GET_DWELL:   next_st.result = {17'h0, mem_dwell[st.index]};
                SPS_CMD_SET_NEXT:    if (cmd_val > 16'(SPS_LOC_MAX)) next_st.err = SPS_ERR_RANGE;
                SPS_CMD_GET_NEXT:    next_st.result = {26'h0, mem_next[st.index]};
                SPS_CMD_MEAS_AMPS, SPS_CMD_READ_AMPS: begin // [RULE10]
                    next_st.result = {16'h0, sense_amps_in}; // [RULE8]
                    if (st.arg[SPS_ARG_EXTRA_BIT]) next_st.quest[SPS_QUEST_WARN_BIT] = 1'b1; // [RULE9]
                end
                SPS_CMD_MEASURE_POTENTIAL_QUERY, SPS_CMD_READ_VOLT: begin // [RULE10]
                    next_st.result = {16'h0, sense_volt_in}; // [RULE8]
                    if (st.arg[SPS_ARG_EXTRA_BIT]) next_st.quest[SPS_QUEST_WARN_BIT] = 1'b1; // [RULE9]
                end
                SPS_CMD_SET_OUTPUT:  next_st.out_en = cmd_val[0]; // [RULE12]
                SPS_CMD_GET_OUTPUT:  next_st.result = {31'h0, st.out_en}; // [RULE13]
                SPS_CMD_SET_DELAY: begin
                    if ({st.arg[17:16], cmd_val} > SPS_DELAY_MAX) next_st.err = SPS_ERR_RANGE;
                    else next_st.delay = {st.arg[17:16], cmd_val}; // [RULE14]
                end
                SPS_CMD_GET_DELAY:   next_st.result = {14'h0, st.delay};
                SPS_CMD_PROG_RUN: begin
                    next_st.cur = st.start; // [RULE16]
                    next_st.running = 1'b1;
                    next_st.seq = SPS_LOAD;
                end
                SPS_CMD_PROG_STOP, SPS_CMD_RESET: begin // [RULE18]
                    next_st.running = 1'b0; // [RULE16]
                    next_st.seq = SPS_IDLE;
                    next_st.tripped = 1'b0;
                end
                SPS_CMD_GET_PROG:    next_st.result = {31'h0, st.running}; // [RULE19]
                SPS_CMD_SET_AMPS: begin
                    if (cmd_val > AMPS_MAX) next_st.err = SPS_ERR_RANGE; // [RULE20]
                    else next_st.amps = clamp_amps(cmd_val, st.hilim); // [RULE20]
                end
                SPS_CMD_SET_VOLT: begin
                    if (cmd_val > VOLT_MAX) next_st.err = SPS_ERR_RANGE;
                    else next_st.volt = cmd_val;
                end
                SPS_CMD_GET_AMPS:     next_st.result = {16'h0, st.amps}; // [RULE21]
                SPS_CMD_GET_AMPS_MAX: next_st.result = {16'h0, AMPS_MAX}; // [RULE21]
                SPS_CMD_GET_AMPS_MIN: next_st.result = 32'h0; // [RULE21]
                SPS_CMD_SET_HILIM:    next_st.hilim = cmd_val;
                SPS_CMD_SET_TRIG_A: begin
                    if (cmd_val > AMPS_MAX) next_st.err = SPS_ERR_RANGE;
                    else next_st.trig_amps = cmd_val; // [RULE22]
                end
                SPS_CMD_GET_TRIG_A:   next_st.result = {16'h0, st.trig_amps};
                SPS_CMD_TRIGGER:      next_st.amps = clamp_amps(st.trig_amps, st.hilim); // [RULE22]
                default:              next_st.err = SPS_ERR_RANGE;
            endcase
        end

        // Output stage: disabled or tripped drives zero, levels kept
        next_st.d_amps = (next_st.out_en && !next_st.tripped) ? next_st.amps : 16'h0; // [RULE12]
        next_st.d_volt = (next_st.out_en && !next_st.tripped) ? next_st.volt : 16'h0; // [RULE12]
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
            st.start <= SPS_RST_START;
            st.index <= SPS_RST_INDEX;
            st.out_en <= 1'b1; // [RULE11]
            st.hilim <= SPS_RST_HILIM;
            st.seq <= SPS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Program memory writes; not cleared by reset so contents are retained
    always_ff @(posedge clk_in) begin
        if (cmd_go && !rst_in) begin
            case (cmd_code)
                SPS_CMD_SET_STEP_V:  if (cmd_val <= VOLT_MAX) mem_volt[st.index] <= cmd_val; // [RULE4]
                SPS_CMD_SET_STEP_OV: if (cmd_val <= VOLT_MAX) mem_ovp[st.index] <= cmd_val; // [RULE5]
                SPS_CMD_SET_DWELL:   if (cmd_val <= 16'(SPS_DWELL_MAX)) mem_dwell[st.index] <= cmd_val[14:0]; // [RULE23]
                SPS_CMD_SET_NEXT:    if (cmd_val <= 16'(SPS_LOC_MAX)) mem_next[st.index] <= cmd_val[5:0];  // [RULE24]
                default: ;
            endcase
        end
    end

    assign avs_readdata_out       = st.rdata;
    assign avs_waitrequest_out    = (avs_read_in || avs_write_in) && !st.ack;
    assign drive_amps_out         = st.d_amps;
    assign drive_volt_out         = st.d_volt;
    assign drive_ovp_out          = st.d_ovp;
    assign keyboard_lock_out      = st.running; // [RULE17] [RULE26]
    assign protection_tripped_out = st.tripped;
endmodule
`default_nettype wire

/* sps_core_asserts.sv */
// Purpose: Port-level checks for sps_core.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every sps_core instance.
`timescale 1ns/100ps
`default_nettype none
module sps_core_asserts (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        fault_ov_in,
    input wire logic        fault_oc_in,
    input wire logic [15:0] drive_amps_out,
    input wire logic [15:0] drive_volt_out,
    input wire logic        keyboard_lock_out,
    input wire logic        protection_tripped_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_req_first;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_recent_write;
        $past(avs_write_in) || $past(avs_write_in, 2) || $past(avs_write_in, 3);
    endsequence
    property p_wait_first;
        $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no stall");
    property p_wait_one;
        s_req_first |=> !avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("long stall");
    property p_read_hold;
        !$past(avs_read_in) |-> $stable(avs_readdata_out);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("readdata moved");
    property p_lock_cause;
        $rose(keyboard_lock_out) |-> s_recent_write;
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock uncaused");
    property p_trip_cause;
        $rose(protection_tripped_out) |-> $past(fault_ov_in || fault_oc_in) || $past(fault_ov_in || fault_oc_in, 2);
    endproperty
    a_trip_cause: assert property (p_trip_cause) else $error("trip uncaused");
    property p_trip_zero;
        protection_tripped_out && $past(protection_tripped_out) |-> drive_amps_out == 16'h0000 && drive_volt_out == 16'h0000;
    endproperty
    a_trip_zero: assert property (p_trip_zero) else $error("drive not zero");
    property p_reset_state;
        $fell(rst_in) |-> !keyboard_lock_out && !protection_tripped_out && drive_amps_out == 16'h0000;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
    property p_amps_hold;
        !keyboard_lock_out && !$past(keyboard_lock_out) && !protection_tripped_out && !$past(protection_tripped_out)
            && !$past(avs_write_in) && !$past(avs_write_in, 2) |-> $stable(drive_amps_out);
    endproperty
    a_amps_hold: assert property (p_amps_hold) else $error("drive moved");
endmodule
bind sps_core sps_core_asserts u_sps_core_asserts (.*);
`default_nettype wire

/* sps_load_model.sv */
// Purpose: Load and fault source facing the drive outputs.
// Assumes: Sensed values follow drive plus a fixed load offset.
// Notes:   Faults appear only when the bench asks for them.
`timescale 1ns/100ps
`default_nettype none
module sps_load_model #(
    parameter logic [15:0] LOAD_OFS = 16'h0010
) (
    input  wire logic        clk_in,
    input  wire logic [15:0] drive_amps_in,
    input  wire logic [15:0] drive_volt_in,
    input  wire logic [1:0]  fault_req_in,
    output logic [15:0]      sense_amps_out,
    output logic [15:0]      sense_volt_out,
    output logic             fault_ov_out,
    output logic             fault_oc_out
);
    always_ff @(posedge clk_in) begin
        sense_amps_out <= drive_amps_in + LOAD_OFS;
        sense_volt_out <= drive_volt_in + LOAD_OFS;
        fault_ov_out   <= fault_req_in[0];
        fault_oc_out   <= fault_req_in[1];
    end
endmodule
`default_nettype wire

/* test_supply_program_sequencer.sv */
// Purpose: Self-checking bench for sps_core.
// Assumes: Dwell and trip units shortened by parameters.
// Notes:   Commands go through ARG then CMD, answers from RESULT.
`timescale 1ns/100ps
`default_nettype none
module test_supply_program_sequencer
    import sps_pkg::*;
;
    localparam logic [15:0] MAXV = 16'hC350;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [1:0]  fault_req = 2'b00;
    logic [31:0] rdata, got;
    logic        wait_rq, f_ov, f_oc, lock, trip;
    logic [15:0] s_amps, s_volt, d_amps, d_volt;
    int          num_errors = 0;
    int          comparisons = 0;
    always #10 clk_in = ~clk_in;
    sps_core #(.AMPS_MAX(MAXV), .VOLT_MAX(MAXV), .DWELL_CYC(4), .TRIP_CYC(2)) uut (
        .clk_in, .rst_in, .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .sense_amps_in(s_amps),
        .sense_volt_in(s_volt), .fault_ov_in(f_ov), .fault_oc_in(f_oc), .drive_amps_out(d_amps),
        .drive_volt_out(d_volt), .drive_ovp_out(), .keyboard_lock_out(lock), .protection_tripped_out(trip));
    sps_load_model load (.clk_in, .drive_amps_in(d_amps), .drive_volt_in(d_volt), .fault_req_in(fault_req),
        .sense_amps_out(s_amps), .sense_volt_out(s_volt), .fault_ov_out(f_ov), .fault_oc_out(f_oc));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk_in);
        while (wait_rq !== 1'b0) @(posedge clk_in);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [31:0] a);
        bus(SPS_REG_ARG, 1'b1, a);
        bus(SPS_REG_CMD, 1'b1, {24'h0, c});
    endtask
    task automatic ask(input logic [7:0] c, input logic [31:0] a, input logic [31:0] e);
        cmd(c, a);
        bus(SPS_REG_RESULT, 1'b0, 32'h0);
        chk(got, e);
    endtask
    task automatic err(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(got, e);
        bus(a, 1'b1, 32'h0);
    endtask
    task automatic pins(input logic [15:0] ea, input logic [1:0] ef);
        @(negedge clk_in);
        chk({14'h0, lock, trip, d_amps}, {14'h0, ef, ea});
        @(posedge clk_in);
    endtask
    task automatic loc(input logic [7:0] n, input logic [15:0] dw, input logic [7:0] nx);
        cmd(SPS_CMD_SET_INDEX, {24'h0, n});
        cmd(SPS_CMD_SET_DWELL, {16'h0, dw});
        cmd(SPS_CMD_SET_NEXT, {24'h0, nx});
        cmd(SPS_CMD_SET_STEP_V, {24'h0, n});
    endtask
    task automatic t_start();
        cmd(SPS_CMD_SET_START, 32'd21);
        ask(SPS_CMD_GET_START, 32'h0, 32'd21);
        cmd(SPS_CMD_SET_START, 32'd41);
        err(SPS_REG_ERROR, 32'h0000FF22);
        ask(SPS_CMD_GET_START, 32'h0, 32'd21);
        bus(8'h3C, 1'b0, 32'h0);
        chk(got, 32'h0);
    endtask
    task automatic t_steps();
        cmd(SPS_CMD_SET_INDEX, 32'd40);
        cmd(SPS_CMD_SET_STEP_V, 32'h1234);
        cmd(SPS_CMD_SET_STEP_OV, 32'h2345);
        cmd(SPS_CMD_SET_INDEX, 32'd22);
        cmd(SPS_CMD_SET_STEP_V, 32'h0777);
        cmd(SPS_CMD_SET_STEP_V, {16'h0, MAXV + 16'h1});
        err(SPS_REG_ERROR, 32'h0000FF22);
        ask(SPS_CMD_GET_STEP_V, 32'h0, 32'h0777);
        cmd(SPS_CMD_SET_INDEX, 32'd40);
        ask(SPS_CMD_GET_STEP_V, 32'h0, 32'h1234);
        cmd(SPS_CMD_SET_STEP_OV, {16'h0, MAXV + 16'h1});
        err(SPS_REG_ERROR, 32'h0000FF22);
        ask(SPS_CMD_GET_STEP_OV, 32'h0, 32'h2345);
        ask(SPS_CMD_GET_INDEX, 32'h0, 32'd40);
    endtask
    task automatic t_out();
        ask(SPS_CMD_GET_OUTPUT, 32'h0, 32'h1);
        cmd(SPS_CMD_SET_AMPS, 32'h0200);
        cmd(SPS_CMD_SET_VOLT, 32'h0100);
        cmd(SPS_CMD_SET_OUTPUT, 32'h0);
        pins(16'h0000, 2'b00);
        ask(SPS_CMD_GET_OUTPUT, 32'h0, 32'h0);
        ask(SPS_CMD_GET_AMPS, 32'h0, 32'h0200);
        cmd(SPS_CMD_SET_OUTPUT, 32'h1);
        pins(16'h0200, 2'b00);
        ask(SPS_CMD_MEAS_AMPS, 32'h0, 32'h0210);
        ask(SPS_CMD_READ_AMPS, 32'h0, 32'h0210);
        ask(SPS_CMD_READ_VOLT, 32'h0, 32'h0110);
        ask(SPS_CMD_MEASURE_POTENTIAL_QUERY, 32'h00010000, 32'h0110);
        err(SPS_REG_QUEST, 32'h00002000);
    endtask
    task automatic t_level();
        cmd(SPS_CMD_SET_HILIM, 32'h0300);
        cmd(SPS_CMD_SET_AMPS, 32'h0400);
        ask(SPS_CMD_GET_AMPS, 32'h0, 32'h0300);
        cmd(SPS_CMD_SET_AMPS, {16'h0, MAXV + 16'h1});
        err(SPS_REG_ERROR, 32'h0000FF22);
        ask(SPS_CMD_GET_AMPS_MAX, 32'h0, {16'h0, MAXV});
        ask(SPS_CMD_GET_AMPS_MIN, 32'h0, 32'h0);
        cmd(SPS_CMD_SET_TRIG_A, 32'h0123);
        pins(16'h0300, 2'b00);
        cmd(SPS_CMD_TRIGGER, 32'h0);
        pins(16'h0123, 2'b00);
    endtask
    task automatic t_prog();
        int n;
        loc(8'd3, 16'd60, 8'd4);
        loc(8'd4, 16'd0, 8'd5);
        loc(8'd5, 16'd2, 8'd0);
        cmd(SPS_CMD_SET_START, 32'd3);
        cmd(SPS_CMD_PROG_RUN, 32'h0);
        chk({16'h0, d_volt}, 32'h3);
        ask(SPS_CMD_GET_PROG, 32'h0, 32'h1);
        chk({31'h0, lock}, 32'h1);
        cmd(SPS_CMD_RESET, 32'h0);
        ask(SPS_CMD_GET_PROG, 32'h0, 32'h0);
        chk({31'h0, lock}, 32'h0);
        loc(8'd3, 16'd1, 8'd4);
        cmd(SPS_CMD_PROG_RUN, 32'h0);
        for (n = 0; n < 500 && lock !== 1'b0; n++) @(negedge clk_in);
        chk({31'h0, lock}, 32'h0);
        ask(SPS_CMD_GET_PROG, 32'h0, 32'h0);
    endtask
    task automatic t_trip();
        cmd(SPS_CMD_SET_DELAY, 32'd3);
        fault_req <= 2'b01;
        repeat (3) @(posedge clk_in);
        fault_req <= 2'b00;
        repeat (10) @(posedge clk_in);
        pins(16'h0123, 2'b00);
        fault_req <= 2'b10;
        repeat (20) @(posedge clk_in);
        pins(16'h0000, 2'b01);
        fault_req <= 2'b00;
        cmd(SPS_CMD_PROG_STOP, 32'h0);
        cmd(SPS_CMD_SET_DELAY, 32'd0);
        fault_req <= 2'b01;
        repeat (3) @(posedge clk_in);
        fault_req <= 2'b00;
        pins(16'h0000, 2'b01);
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_start();
        t_steps();
        t_out();
        t_level();
        t_prog();
        t_trip();
        end_of_test();
    end
endmodule
`default_nettype wire
